// *** verilog/nirq_cfg.svh ***
// Register offsets, field positions, reset values and limits of the interrupt and status block
`ifndef NIRQ_CFG_SVH
`define NIRQ_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices (printed offsets are indices, byte address = 4 * index)
// ----------------------------------------------------------------------------
`define NIRQ_IDX_TN_MASK      8'h15
`define NIRQ_IDX_EW_MASK      8'h16
`define NIRQ_IDX_MAIN         8'h17
`define NIRQ_IDX_TN_STAT      8'h18
`define NIRQ_IDX_EW_STAT      8'h19
`define NIRQ_IDX_FIFO_FILL    8'h1a
`define NIRQ_IDX_FIFO_LAST    8'h1b
`define NIRQ_IDX_COLL_POS     8'h1c
`define NIRQ_IDX_MAIN_MASK    8'h14
`define NIRQ_ADDR_W           10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define NIRQ_MAIN_TIM_BIT     1
`define NIRQ_MAIN_ERR_BIT     0
`define NIRQ_EW_WT_BIT        3
`define NIRQ_TN_CAC_BIT       2
`define NIRQ_TN_CAT_BIT       1

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define NIRQ_RST_BYTE         8'h00
`define NIRQ_FIFO_MAX         7'h60
`define NIRQ_COLL_MAX_BYTES   4'hf

`endif

// *** verilog/nirq_pkg.sv ***
// Types shared by the interrupt and status block
package nirq_pkg;

  typedef enum logic [1:0] {
    NIRQ_BUS_IDLE,
    NIRQ_BUS_DATA
  } nirq_bus_st_t;

  typedef struct packed {
    logic [3:0] bytes;
    logic [2:0] bits;
    logic       parity;
  } nirq_coll_t;

endpackage : nirq_pkg

// *** verilog/nirq_ahb_slave.sv ***
// AHB-Lite slave front end: catches the address phase, gives read and write strobes
`timescale 1ns/100ps
`include "nirq_cfg.svh"

module nirq_ahb_slave (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic                          rd_stb,
  output logic                          wr_stb,
  output logic [7:0]                    reg_idx
);

  typedef struct packed {
    nirq_pkg::nirq_bus_st_t st;
    logic                   wr;
    logic [7:0]             idx;
  } nirq_slv_state_t;

  nirq_slv_state_t s_q;
  nirq_slv_state_t s_d;
  logic            take;

  // A valid, word-sized transfer is taken on any NONSEQ/SEQ address phase
  assign take = hsel && hready && htrans[1] && (hsize == 3'h2);

  always_comb begin
    s_d = s_q;
    if (hready) begin
      s_d.st = take ? nirq_pkg::NIRQ_BUS_DATA : nirq_pkg::NIRQ_BUS_IDLE;
      if (take) begin
        s_d.wr  = hwrite;
        s_d.idx = haddr[`NIRQ_ADDR_W-1:2];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{st: nirq_pkg::NIRQ_BUS_IDLE, wr: 1'b0, idx: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  // Zero wait states; every answer is OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign reg_idx   = s_q.idx;

  always_comb begin
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    case (s_q.st)
      nirq_pkg::NIRQ_BUS_DATA: begin
        rd_stb = !s_q.wr;
        wr_stb = s_q.wr;
      end
      default: begin
        rd_stb = 1'b0;
        wr_stb = 1'b0;
      end
    endcase
  end

endmodule : nirq_ahb_slave

// *** verilog/nirq_flag_bank.sv ***
// Bank of eight sticky event flags with clear-on-read and pending summary
`timescale 1ns/100ps
`include "nirq_cfg.svh"

module nirq_flag_bank (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       soft_clr,
  input  wire logic [7:0] evt,
  input  wire logic       rd_clr,
  input  wire logic [7:0] mask,
  output logic [7:0]      flags,
  output logic            any_set,
  output logic            any_unmasked
);

  typedef struct packed {
    logic [7:0] f;
  } nirq_bank_state_t;

  nirq_bank_state_t s_q;
  nirq_bank_state_t s_d;

  // Each flag: an event in the cycle of the clearing read still lands
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_flag
      always_comb begin
        s_d.f[g] = soft_clr ? 1'b0 : (evt[g] | (s_q.f[g] & ~rd_clr));
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{f: `NIRQ_RST_BYTE};
    end else begin
      s_q <= s_d;
    end
  end

  assign flags        = s_q.f;
  assign any_set      = |s_q.f;
  assign any_unmasked = |(s_q.f & ~mask);

endmodule : nirq_flag_bank

// *** verilog/nirq_top.sv ***
// Interrupt, FIFO status and collision position block with AHB-Lite register access
//
// How it works
// - Timer/NFC mask register, one bit per source; a one blocks that source.
// - Error/wake-up mask register, one bit per event; a one blocks it.
// - Main bit 7 set when the enabled oscillator reports stable.
// - Main bit 6 set on FIFO water level, in receive or transmit.
// - Main bits 5..2: receive start, receive end, transmit end, bit collision.
// - Main bits 1 and 0 summarise the timer/NFC and error/wake-up registers.
// - Reading main clears it, except bits 1 and 0 which follow secondaries.
// - Timer/NFC flags: command done, timers, field on/off, CA, guard, bit rate.
// - CA collision flag when field seen; otherwise guard-time flag after field on.
// - Error flags: CRC, parity, soft framing and hard framing kept apart.
// - Wake-up timer flag bit 3 only when interrupt at every timeout is chosen.
// - Amplitude, phase, capacitance wake-up flags when delta exceeds reference.
// - Power-up or set-default clears every flag, status and mask register.
// - Seven-bit count of unread FIFO bytes, 0 to 96.
// - Underflow flag bit 6 on over-read, overflow flag bit 5 on overflow.
// - Bit 4 flags incomplete last byte, three-bit count of its valid bits.
// - Bit 0 flags a missing parity bit in the last byte.
// - Empty FIFO reports zero count and clears incomplete flag and bit count.
// - Reading the second FIFO status clears last-byte fields and parity flag.
// - Collision stores byte count, bit count and a first-collision parity flag.
// - Collision position updates only inside anticollision frame length.
`timescale 1ns/100ps
`include "nirq_cfg.svh"

module nirq_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Control from the rest of the device
  input  wire logic        set_default,
  input  wire logic        osc_enable,
  input  wire logic        osc_stable,
  input  wire logic        water_level_evt,
  input  wire logic        rx_start_evt,
  input  wire logic        rx_end_evt,
  input  wire logic        tx_end_evt,
  input  wire logic        bit_collision_evt,
  input  wire logic        dct_done_evt,
  input  wire logic        nrt_expire_evt,
  input  wire logic        gpt_expire_evt,
  input  wire logic        field_on_evt,
  input  wire logic        field_off_evt,
  input  wire logic        ca_active,
  input  wire logic        ca_field_seen,
  input  wire logic        guard_time_done,
  input  wire logic        bit_rate_found_evt,
  input  wire logic        crc_err_evt,
  input  wire logic        parity_err_evt,
  input  wire logic        soft_framing_evt,
  input  wire logic        hard_framing_evt,
  input  wire logic        wake_timeout_evt,
  input  wire logic        wake_irq_every,
  input  wire logic        wake_amp_delta_evt,
  input  wire logic        wake_phase_delta_evt,
  input  wire logic        wake_cap_delta_evt,
  input  wire logic [6:0]  fifo_count,
  input  wire logic        fifo_underflow_evt,
  input  wire logic        fifo_overflow_evt,
  input  wire logic        last_byte_evt,
  input  wire logic [2:0]  last_byte_bits,
  input  wire logic        last_byte_no_parity,
  input  wire logic        coll_evt,
  input  wire logic [3:0]  coll_bytes,
  input  wire logic [2:0]  coll_bits,
  input  wire logic        coll_in_parity,
  input  wire logic        coll_in_ac_frame,
  input  wire logic        rx_frame_start,
  output logic             irq,
  output logic             field_on_req
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]          main_mask;
    logic [7:0]          tn_mask;
    logic [7:0]          ew_mask;
    logic [7:2]          main_flags;
    logic [6:0]          fill;
    logic                unf;
    logic                ovr;
    logic                ncp;
    logic [2:0]          last_byte_bit_count;
    logic                last_byte_parity_missing;
    nirq_pkg::nirq_coll_t coll;
    logic                coll_seen;
    logic                osc_stable_q;
    logic                ca_field_on;
    logic [31:0]         rdata;
    logic                irq;
  } nirq_state_t;

  nirq_state_t s_q;
  nirq_state_t s_d;

  logic        rd_take;
  logic [7:0]  rd_idx;
  logic        wr_stb;
  logic [7:0]  reg_idx;
  logic [7:0]  tn_evt;
  logic [7:0]  ew_evt;
  logic [7:0]  tn_flags;
  logic [7:0]  ew_flags;
  logic        tn_any;
  logic        ew_any;
  logic        tn_unm;
  logic        ew_unm;
  logic        rd_main;
  logic        rd_tn;
  logic        rd_ew;
  logic        rd_last;
  logic        cat_evt;
  logic [7:0]  main_view;
  logic [7:0]  rd_byte;

  // --------------------------------------------------------------------------
  // Bus front end and secondary flag banks
  // --------------------------------------------------------------------------
  nirq_ahb_slave u_slv (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rd_stb    (),
    .wr_stb    (wr_stb),
    .reg_idx   (reg_idx)
  );

  // Reads decode in the address phase so the registered byte stands in the data phase;
  // clearing at that same edge keeps an event that lands there instead of losing it
  assign rd_take = hsel && hready && htrans[1] && !hwrite && (hsize == 3'h2);
  assign rd_idx  = haddr[`NIRQ_ADDR_W-1:2];
  assign rd_main = rd_take && (rd_idx == `NIRQ_IDX_MAIN);
  assign rd_tn   = rd_take && (rd_idx == `NIRQ_IDX_TN_STAT);
  assign rd_ew   = rd_take && (rd_idx == `NIRQ_IDX_EW_STAT);
  assign rd_last = rd_take && (rd_idx == `NIRQ_IDX_FIFO_LAST);

  // Guard flag fires once per field switch-on; the pulse avoids a level repeating
  assign cat_evt = s_q.ca_field_on && guard_time_done;

  assign tn_evt = {dct_done_evt, nrt_expire_evt, gpt_expire_evt, field_on_evt,
                   field_off_evt, ca_active && ca_field_seen, cat_evt,
                   bit_rate_found_evt};
  assign ew_evt = {crc_err_evt, parity_err_evt, soft_framing_evt, hard_framing_evt,
                   wake_timeout_evt && wake_irq_every, wake_amp_delta_evt,
                   wake_phase_delta_evt, wake_cap_delta_evt};

  nirq_flag_bank u_tn (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .soft_clr     (set_default),
    .evt          (tn_evt),
    .rd_clr       (rd_tn),
    .mask         (s_q.tn_mask),
    .flags        (tn_flags),
    .any_set      (tn_any),
    .any_unmasked (tn_unm)
  );

  nirq_flag_bank u_ew (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .soft_clr     (set_default),
    .evt          (ew_evt),
    .rd_clr       (rd_ew),
    .mask         (s_q.ew_mask),
    .flags        (ew_flags),
    .any_set      (ew_any),
    .any_unmasked (ew_unm)
  );

  // Bits 1 and 0 are live summaries, so they drop only when the secondary is read or set default clears it
  assign main_view = {s_q.main_flags, tn_any, ew_any};

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  always_comb begin
    case (rd_idx)
      `NIRQ_IDX_MAIN_MASK: rd_byte = s_q.main_mask;
      `NIRQ_IDX_TN_MASK:   rd_byte = s_q.tn_mask;
      `NIRQ_IDX_EW_MASK:   rd_byte = s_q.ew_mask;
      `NIRQ_IDX_MAIN:      rd_byte = main_view;
      `NIRQ_IDX_TN_STAT:   rd_byte = tn_flags;
      `NIRQ_IDX_EW_STAT:   rd_byte = ew_flags;
      `NIRQ_IDX_FIFO_FILL: rd_byte = {1'b0, s_q.fill};
      `NIRQ_IDX_FIFO_LAST: rd_byte = {1'b0, s_q.unf, s_q.ovr, s_q.ncp,
                                      s_q.last_byte_bit_count,
                                      s_q.last_byte_parity_missing};
      `NIRQ_IDX_COLL_POS:  rd_byte = {s_q.coll.bytes, s_q.coll.bits, s_q.coll.parity};
      default:             rd_byte = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Read data is registered at the address edge and stands for the data phase only
    s_d.rdata = rd_take ? {24'h00_0000, rd_byte} : 32'h0000_0000;

    // Mask writes steer the interrupt request
    if (wr_stb) begin
      case (reg_idx)
        `NIRQ_IDX_MAIN_MASK: s_d.main_mask = hwdata[7:0];
        `NIRQ_IDX_TN_MASK:   s_d.tn_mask   = hwdata[7:0];
        `NIRQ_IDX_EW_MASK:   s_d.ew_mask   = hwdata[7:0];
        default: begin
        end
      endcase
    end

    // Main flags: read clears, new events still win
    s_d.osc_stable_q = osc_enable && osc_stable;
    if (rd_main) begin
      s_d.main_flags = 6'h00;
    end
    if (osc_enable && osc_stable && !s_q.osc_stable_q) begin
      s_d.main_flags[7] = 1'b1;
    end
    if (water_level_evt) begin
      s_d.main_flags[6] = 1'b1;
    end
    if (rx_start_evt) begin
      s_d.main_flags[5] = 1'b1;
    end
    if (rx_end_evt) begin
      s_d.main_flags[4] = 1'b1;
    end
    if (tx_end_evt) begin
      s_d.main_flags[3] = 1'b1;
    end
    if (bit_collision_evt) begin
      s_d.main_flags[2] = 1'b1;
    end

    // Collision avoidance: no field seen, so switch our own field on
    if (ca_active && !ca_field_seen && !s_q.ca_field_on) begin
      s_d.ca_field_on = 1'b1;
    end else if (cat_evt || !ca_active) begin
      s_d.ca_field_on = 1'b0;
    end

    // FIFO fill level, clamped to the largest legal count
    s_d.fill = (fifo_count > `NIRQ_FIFO_MAX) ? `NIRQ_FIFO_MAX : fifo_count;

    if (rd_last) begin
      s_d.ncp                      = 1'b0;
      s_d.last_byte_bit_count      = 3'h0;
      s_d.last_byte_parity_missing = 1'b0;
    end
    if (fifo_underflow_evt) begin
      s_d.unf = 1'b1;
    end
    if (fifo_overflow_evt) begin
      s_d.ovr = 1'b1;
    end
    if (last_byte_evt) begin
      s_d.ncp                      = (last_byte_bits != 3'h0);
      s_d.last_byte_bit_count      = last_byte_bits;
      s_d.last_byte_parity_missing = last_byte_no_parity;
    end
    // Empty FIFO overrides any pending partial-byte report
    if (fifo_count == 7'h00) begin
      s_d.fill                = 7'h00;
      s_d.ncp                 = 1'b0;
      s_d.last_byte_bit_count = 3'h0;
    end

    // Collision position: first collision of a frame inside anticollision length
    if (rx_frame_start) begin
      s_d.coll_seen = 1'b0;
    end
    if (coll_evt) begin
      s_d.coll_seen = 1'b1;
      if (coll_in_ac_frame && !s_q.coll_seen) begin
        s_d.coll.bytes  = coll_bytes;
        s_d.coll.bits   = coll_bits;
        s_d.coll.parity = coll_in_parity;
      end
    end

    // Request follows unmasked pending flags, one cycle behind them
    s_d.irq = |(main_view[7:2] & ~s_q.main_mask[7:2]) | tn_unm | ew_unm;

    // Set default wipes everything, including the masks
    if (set_default) begin
      s_d = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign hrdata       = s_q.rdata;
  assign irq          = s_q.irq;
  assign field_on_req = s_q.ca_field_on;

endmodule : nirq_top

// *** tb/nirq_top_sva.sv ***
// Port-level assertions for the interrupt and status block
`timescale 1ns/100ps

module nirq_top_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        set_default,
  input wire logic        ca_active,
  input wire logic        ca_field_seen,
  input wire logic        guard_time_done,
  input wire logic [6:0]  fifo_count,
  input wire logic        irq,
  input wire logic        field_on_req
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic rd_fill;
  assign rd_fill = hsel && hready && htrans[1] && !hwrite && hsize == 3'h2
                   && haddr == 32'h0000_0068;

  AST_CA_RAISE: assert property (
    ca_active && !ca_field_seen && !field_on_req && !set_default |=> field_on_req)
    else $error("field request did not rise");
  AST_CA_GUARD: assert property (field_on_req && guard_time_done |=> !field_on_req)
    else $error("field request kept after guard time");
  AST_CA_STOP: assert property (!ca_active |=> !field_on_req)
    else $error("field request without avoidance");
  AST_CA_CAUSE: assert property (
    $rose(field_on_req) |-> $past(ca_active) && !$past(ca_field_seen))
    else $error("field request rose without cause");
  AST_DEFAULT_IRQ: assert property (set_default |=> ##1 !irq)
    else $error("irq kept after set default");
  AST_DEFAULT_FIELD: assert property (set_default |=> !field_on_req)
    else $error("field request kept after set default");
  AST_FILL_MAX: assert property (
    rd_fill |=> hrdata[31:7] == 25'h000_0000 && hrdata[6:0] <= 7'h60)
    else $error("fill level out of range");
  AST_FILL_EMPTY: assert property (
    rd_fill && fifo_count == 7'h00 && $past(fifo_count) == 7'h00 |=> hrdata == 32'h0000_0000)
    else $error("empty fill level not zero");
endmodule : nirq_top_sva

bind nirq_top nirq_top_sva i_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hrdata(hrdata),
  .set_default(set_default), .ca_active(ca_active), .ca_field_seen(ca_field_seen),
  .guard_time_done(guard_time_done), .fifo_count(fifo_count), .irq(irq),
  .field_on_req(field_on_req));

// *** tb/nirq_host.sv ***
// Bus master model of the microcontroller reading the status registers
`timescale 1ns/100ps
`include "nirq_cfg.svh"

module nirq_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // Waits on hready rather than a fixed count, so a slower slave still works
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rdat);
    hsel   <= 1'b1;
    haddr  <= {22'h00_0000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rdat = hrdata[7:0];
  endtask : xfer

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    xfer(1'b0, idx, 8'h00, d);
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] d;
    xfer(1'b1, idx, v, d);
  endtask : wr

  // Last-byte fields are lost once read, so both are fetched before any data
  task automatic fifo_status(output logic [7:0] fill, output logic [7:0] last);
    rd(`NIRQ_IDX_FIFO_FILL, fill);
    rd(`NIRQ_IDX_FIFO_LAST, last);
  endtask : fifo_status
endmodule : nirq_host

// *** tb/testbench.sv ***
// Self-checking bench for the interrupt, FIFO status and collision block
`timescale 1ns/100ps
`include "nirq_cfg.svh"

module testbench;
  localparam logic [7:0] r_tnm = `NIRQ_IDX_TN_MASK, r_ewm = `NIRQ_IDX_EW_MASK;
  localparam logic [7:0] r_main = `NIRQ_IDX_MAIN, r_tn = `NIRQ_IDX_TN_STAT;
  localparam logic [7:0] r_ew = `NIRQ_IDX_EW_STAT, r_fill = `NIRQ_IDX_FIFO_FILL;
  localparam logic [7:0] r_last = `NIRQ_IDX_FIFO_LAST, r_coll = `NIRQ_IDX_COLL_POS;
  logic        hclk = 1'b0, hresetn = 1'b0;
  logic [7:0]  mev = 8'h00, tev = 8'h00, eev = 8'h00;
  logic [5:0]  xev = 6'h00;
  logic        osc_en = 1'b0, osc_st = 1'b0, ca_act = 1'b0, ca_fs = 1'b0, guard = 1'b0;
  logic        wk_every = 1'b0, lnp = 1'b0, cpar = 1'b0, cac = 1'b0;
  logic [6:0]  fcnt = 7'h00;
  logic [2:0]  lbits = 3'h0, cbits = 3'h0;
  logic [3:0]  cbytes = 4'h0;
  logic        hsel, hwrite, hreadyout, hresp, irq, field_on_req;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          n_fail = 0, compares = 0;

  nirq_top i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .set_default(xev[5]),
    .osc_enable(osc_en), .osc_stable(osc_st), .water_level_evt(mev[6]),
    .rx_start_evt(mev[5]), .rx_end_evt(mev[4]), .tx_end_evt(mev[3]),
    .bit_collision_evt(mev[2]), .dct_done_evt(tev[7]), .nrt_expire_evt(tev[6]),
    .gpt_expire_evt(tev[5]), .field_on_evt(tev[4]), .field_off_evt(tev[3]),
    .ca_active(ca_act), .ca_field_seen(ca_fs), .guard_time_done(guard),
    .bit_rate_found_evt(tev[0]), .crc_err_evt(eev[7]), .parity_err_evt(eev[6]),
    .soft_framing_evt(eev[5]), .hard_framing_evt(eev[4]), .wake_timeout_evt(eev[3]),
    .wake_irq_every(wk_every), .wake_amp_delta_evt(eev[2]),
    .wake_phase_delta_evt(eev[1]), .wake_cap_delta_evt(eev[0]), .fifo_count(fcnt),
    .fifo_underflow_evt(xev[0]), .fifo_overflow_evt(xev[1]), .last_byte_evt(xev[2]),
    .last_byte_bits(lbits), .last_byte_no_parity(lnp), .coll_evt(xev[3]),
    .coll_bytes(cbytes), .coll_bits(cbits), .coll_in_parity(cpar),
    .coll_in_ac_frame(cac), .rx_frame_start(xev[4]), .irq(irq),
    .field_on_req(field_on_req));

  nirq_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    forever #20 hclk = ~hclk;
  end

  // --------------------------------
  // Checking helpers
  // --------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chk1(input string n, input logic e, input logic g);
    chk(n, {7'h00, e}, {7'h00, g});
  endtask : chk1

  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(idx, d);
    chk($sformatf("register %h", idx), e, d);
  endtask : rchk

  // One-cycle event pulse, then one edge for irq to follow the flag
  task automatic pulse(input logic [7:0] m, input logic [7:0] t, input logic [7:0] e,
                       input logic [5:0] x);
    mev <= m;
    tev <= t;
    eev <= e;
    xev <= x;
    @(posedge hclk);
    mev <= 8'h00;
    tev <= 8'h00;
    eev <= 8'h00;
    xev <= 6'h00;
    @(posedge hclk);
  endtask : pulse

  task automatic all_zero();
    for (int i = 20; i <= 28; i++) begin
      rchk(8'(i), 8'h00);
    end
  endtask : all_zero

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_bus();
    i_host.wr(r_tnm, 8'ha5);
    i_host.wr(r_ewm, 8'h5a);
    i_host.wr(8'h1f, 8'hff);
    i_host.wr(r_fill, 8'h33);
    i_host.wr(r_main, 8'hff);
    rchk(r_tnm, 8'ha5);
    rchk(r_ewm, 8'h5a);
    rchk(8'h1f, 8'h00);
    rchk(r_fill, 8'h00);
    rchk(r_main, 8'h00);
    i_host.wr(r_tnm, 8'h00);
    i_host.wr(r_ewm, 8'h00);
  endtask : t_bus

  task automatic t_main();
    osc_en <= 1'b1;
    osc_st <= 1'b1;
    pulse(8'h7c, 8'h00, 8'h00, 6'h00);
    rchk(r_main, 8'hfc);
    rchk(r_main, 8'h00);
    pulse(8'h00, 8'hf9, 8'h00, 6'h00);
    #1 chk1("irq", 1'b1, irq);
    rchk(r_main, 8'h02);
    rchk(r_main, 8'h02);
    rchk(r_tn, 8'hf9);
    rchk(r_main, 8'h00);
    #1 chk1("irq", 1'b0, irq);
  endtask : t_main

  task automatic t_ca();
    ca_act <= 1'b1;
    ca_fs  <= 1'b1;
    repeat (2) @(posedge hclk);
    #1 chk1("field_on_req", 1'b0, field_on_req);
    ca_fs <= 1'b0;
    repeat (2) @(posedge hclk);
    #1 chk1("field_on_req", 1'b1, field_on_req);
    guard <= 1'b1;
    @(posedge hclk);
    guard  <= 1'b0;
    ca_act <= 1'b0;
    @(posedge hclk);
    #1 chk1("field_on_req", 1'b0, field_on_req);
    rchk(r_tn, 8'h06);
  endtask : t_ca

  task automatic t_err();
    pulse(8'h00, 8'h00, 8'h08, 6'h00);
    rchk(r_ew, 8'h00);
    wk_every <= 1'b1;
    pulse(8'h00, 8'h00, 8'hff, 6'h00);
    rchk(r_main, 8'h01);
    rchk(r_ew, 8'hff);
    rchk(r_ew, 8'h00);
  endtask : t_err

  task automatic t_mask();
    i_host.wr(r_tnm, 8'h80);
    i_host.wr(r_ewm, 8'h08);
    pulse(8'h00, 8'h80, 8'h08, 6'h00);
    @(posedge hclk);
    #1 chk1("irq", 1'b0, irq);
    rchk(r_tn, 8'h80);
    rchk(r_ew, 8'h08);
    pulse(8'h00, 8'h00, 8'h01, 6'h00);
    #1 chk1("irq", 1'b1, irq);
    rchk(r_ew, 8'h01);
    i_host.wr(r_tnm, 8'h00);
    i_host.wr(r_ewm, 8'h00);
  endtask : t_mask

  task automatic t_fifo();
    logic [7:0] f1, f2;
    fcnt  <= 7'h60;
    lbits <= 3'h5;
    lnp   <= 1'b1;
    pulse(8'h00, 8'h00, 8'h00, 6'h07);
    i_host.fifo_status(f1, f2);
    chk("fill", 8'h60, f1);
    chk("last", 8'h7b, f2);
    rchk(r_last, 8'h60);
    pulse(8'h00, 8'h00, 8'h00, 6'h04);
    fcnt <= 7'h00;
    @(posedge hclk);
    rchk(r_fill, 8'h00);
    rchk(r_last, 8'h61);
    rchk(r_last, 8'h60);
  endtask : t_fifo

  task automatic t_coll();
    cbytes <= 4'h3;
    cbits  <= 3'h5;
    cpar   <= 1'b1;
    cac    <= 1'b1;
    pulse(8'h00, 8'h00, 8'h00, 6'h10);
    pulse(8'h00, 8'h00, 8'h00, 6'h08);
    cbytes <= 4'h7;
    pulse(8'h00, 8'h00, 8'h00, 6'h08);
    rchk(r_coll, 8'h3b);
    cac <= 1'b0;
    pulse(8'h00, 8'h00, 8'h00, 6'h10);
    pulse(8'h00, 8'h00, 8'h00, 6'h08);
    rchk(r_coll, 8'h3b);
    cac  <= 1'b1;
    cpar <= 1'b0;
    pulse(8'h00, 8'h00, 8'h00, 6'h10);
    pulse(8'h00, 8'h00, 8'h00, 6'h08);
    cpar <= 1'b1;
    pulse(8'h00, 8'h00, 8'h00, 6'h08);
    rchk(r_coll, 8'h7a);
  endtask : t_coll

  task automatic t_default();
    i_host.wr(r_tnm, 8'hff);
    i_host.wr(r_ewm, 8'hff);
    pulse(8'h7c, 8'hff, 8'hff, 6'h03);
    // Drop the oscillator enable along with set default, so no new stable event follows
    osc_en <= 1'b0;
    pulse(8'h00, 8'h00, 8'h00, 6'h20);
    all_zero();
    #1 chk1("irq", 1'b0, irq);
  endtask : t_default

  initial begin
    #200_000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    all_zero();
    t_bus();
    t_main();
    t_ca();
    t_err();
    t_mask();
    t_fifo();
    t_coll();
    t_default();
    report_and_stop();
  end
endmodule : testbench
